// [verilog/lpc_regs.vh]
// Register indexes, field positions, write masks, reset values and gray limits of the panel control block.
`ifndef LPC_REGS_VH
`define LPC_REGS_VH
`define LPC_IDX_START_TOP   8'h26
`define LPC_IDX_CURSOR_TOP  8'h27
`define LPC_IDX_COLUMN      8'hd0
`define LPC_IDX_WIDTH       8'hd1
`define LPC_IDX_ROW         8'hd2
`define LPC_IDX_HALF        8'hd3
`define LPC_IDX_CTL1        8'hd4
`define LPC_IDX_CTL2        8'hd5
`define LPC_IDX_GRAY        8'hd6
`define LPC_IDX_ACINV       8'hd9
`define LPC_IDX_BORDER      8'hda
`define LPC_IDX_CTL3        8'hdb
`define LPC_MASK_TOP        8'h03
`define LPC_MASK_GRAY       8'h8f
`define LPC_MASK_BORDER     8'h0f
`define LPC_MASK_CTL3       8'he0
`define LPC_RST_ZERO        8'h00
`define LPC_RST_GRAY        8'h8d
`define LPC_RST_GRAY_VAL    8'h0d
`define LPC_C1_HALF9        7
`define LPC_C1_ROW9         6
`define LPC_C1_WIDTH9       5
`define LPC_C1_COL9         4
`define LPC_C1_CENTER       3
`define LPC_C1_EXTRA        2
`define LPC_C1_FRADDR       1
`define LPC_C1_RETRACE      0
`define LPC_C2_PALETTE      7
`define LPC_C2_REVERSE      6
`define LPC_C2_ATTR         5
`define LPC_C2_FORCE16      4
`define LPC_C2_RED_HI       1
`define LPC_C2_RED_LO       0
`define LPC_GR_STIPPLE      7
`define LPC_C3_LEGACY       7
`define LPC_C3_MCLKINV      6
`define LPC_C3_TRISTATE     5
`define LPC_GRAY_MAX        4'hf
`define LPC_GRAY_MIN        4'h0
`endif

// [verilog/lpc_panel_control.v]
// Flat-panel control registers and the timing and pixel logic they steer.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_regs.vh"
module lpc_panel_control #(
    parameter LINE_W = 10
) (
    // Clock and reset
    input  wire              i_clock,
    input  wire              i_nrst,
    // Indexed register port
    input  wire [7:0]        i_index,
    input  wire [7:0]        i_wdata,
    input  wire              i_write,
    output wire [7:0]        o_rdata,
    // Mode and timing inputs from the display controller
    input  wire              i_lcd_mode,
    input  wire              i_text_mode,
    input  wire              i_expanded,
    input  wire              i_line_clk_raw,
    input  wire              i_retrace,
    input  wire              i_frame_start,
    input  wire [LINE_W-1:0] i_image_lines,
    input  wire [LINE_W-1:0] i_panel_lines,
    input  wire [LINE_W-1:0] i_line_num,
    input  wire              i_lower_half_start,
    input  wire              i_frame_addr8,
    input  wire              i_mclk,
    // Pixel path
    input  wire [7:0]        i_pixel_index,
    input  wire [3:0]        i_pixel_gray,
    input  wire              i_pixel_valid,
    input  wire              i_border,
    input  wire              i_text_contrast_gray,
    input  wire [8:0]        i_row9_pixels,
    input  wire              i_palette_we,
    input  wire [7:0]        i_palette_addr,
    input  wire [3:0]        i_palette_gray,
    input  wire              i_dot_clk,
    // Panel outputs
    output reg               o_line_clk,
    output reg               o_ac_invert,
    output reg  [3:0]        o_gray,
    output reg  [1:0]        o_reduced,
    output reg               o_drop_pixel,
    output reg               o_image_active,
    output reg  [3:0]        o_gray_phase,
    output reg               o_vert_stipple,
    output wire              o_irq_pin_out,
    output wire              o_irq_pin_oe_n,
    output wire [7:0]        o_pixel_out,
    output wire              o_pixel_oe_n,
    output wire              o_video_dot_clock_out,
    output wire              o_dot_clock_oe_n,
    output wire              o_mclk_ga,
    output wire              o_force16,
    output wire              o_legacy_color,
    output wire [1:0]        o_start_addr_top,
    output wire [1:0]        o_cursor_addr_top,
    output wire [8:0]        o_panel_half_height,
    output wire [8:0]        o_vertical_image_offset,
    output wire [8:0]        o_panel_width_nibbles,
    output wire [8:0]        o_column_pan_offset
);

    reg              rst_s1;
    reg              rst_s2;
    reg  [7:0]       start_addr_a_top_bits;
    reg  [7:0]       cursor_loc_top_bits;
    reg  [7:0]       column_pan_offset;
    reg  [7:0]       panel_width_nibbles;
    reg  [7:0]       vertical_image_offset;
    reg  [7:0]       panel_half_height;
    reg  [7:0]       panel_control_one;
    reg  [7:0]       panel_control_two;
    reg  [7:0]       gray_line_offset;
    reg  [7:0]       ac_inversion_period;
    reg  [7:0]       border_gray_shade;
    reg  [7:0]       panel_control_three;
    reg  [7:0]       rdata;
    reg  [3:0]       palette [0:255];
    reg  [3:0]       pal_gray;
    reg  [7:0]       ac_count;
    reg              lc_s1;
    reg              lc_s2;
    reg              lc_d;
    reg              rt_s1;
    reg              rt_s2;
    reg              lh_s1;
    reg              lh_s2;
    reg              lh_d;
    reg              extra_pend;
    reg              first_line;
    reg  [LINE_W-1:0] top_blank;
    reg  [3:0]       next_gray;
    reg  [3:0]       pix_gray;
    wire             rst_n;
    wire             line_edge;
    wire             lower_edge;
    wire [LINE_W-1:0] blank_lines;
    wire [LINE_W-1:0] first_image_line;

    // Reset is released through two stages so all registers except the palette and pal_gray leave reset together.
    always @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end
    assign rst_n = rst_s2;

    // Registers without a printed reset value clear to zero.
    always @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            start_addr_a_top_bits <= `LPC_RST_ZERO;
            cursor_loc_top_bits   <= `LPC_RST_ZERO;
            column_pan_offset     <= `LPC_RST_ZERO;
            panel_width_nibbles   <= `LPC_RST_ZERO;
            vertical_image_offset <= `LPC_RST_ZERO;
            panel_half_height     <= `LPC_RST_ZERO;
            panel_control_one     <= `LPC_RST_ZERO;
            panel_control_two     <= `LPC_RST_ZERO;
            gray_line_offset      <= `LPC_RST_GRAY_VAL;
            ac_inversion_period   <= `LPC_RST_ZERO;
            border_gray_shade     <= `LPC_RST_ZERO;
            panel_control_three   <= `LPC_RST_ZERO;
        end
        else if (i_write)
        begin
            case (i_index)
                `LPC_IDX_START_TOP:  start_addr_a_top_bits <= i_wdata & `LPC_MASK_TOP;
                `LPC_IDX_CURSOR_TOP: cursor_loc_top_bits <= i_wdata & `LPC_MASK_TOP;
                `LPC_IDX_COLUMN:     column_pan_offset <= i_wdata;
                `LPC_IDX_WIDTH:      panel_width_nibbles <= i_wdata;
                `LPC_IDX_ROW:        vertical_image_offset <= i_wdata;
                `LPC_IDX_HALF:       panel_half_height <= i_wdata;
                `LPC_IDX_CTL1:       panel_control_one <= i_wdata;
                `LPC_IDX_CTL2:       panel_control_two <= i_wdata;
                `LPC_IDX_GRAY:       gray_line_offset <= i_wdata & `LPC_MASK_GRAY;
                `LPC_IDX_ACINV:      ac_inversion_period <= i_wdata;
                `LPC_IDX_BORDER:     border_gray_shade <= i_wdata & `LPC_MASK_BORDER;
                `LPC_IDX_CTL3:       panel_control_three <= i_wdata & `LPC_MASK_CTL3;
                default:             ;
            endcase
        end
    end

    // Unmapped indexes read as zero.
    always @*
    begin
        case (i_index)
            `LPC_IDX_START_TOP:  rdata = start_addr_a_top_bits;
            `LPC_IDX_CURSOR_TOP: rdata = cursor_loc_top_bits;
            `LPC_IDX_COLUMN:     rdata = column_pan_offset;
            `LPC_IDX_WIDTH:      rdata = panel_width_nibbles;
            `LPC_IDX_ROW:        rdata = vertical_image_offset;
            `LPC_IDX_HALF:       rdata = panel_half_height;
            `LPC_IDX_CTL1:       rdata = panel_control_one;
            `LPC_IDX_CTL2:       rdata = panel_control_two;
            `LPC_IDX_GRAY:       rdata = gray_line_offset;
            `LPC_IDX_ACINV:      rdata = ac_inversion_period;
            `LPC_IDX_BORDER:     rdata = border_gray_shade;
            `LPC_IDX_CTL3:       rdata = panel_control_three;
            default:             rdata = `LPC_RST_ZERO;
        endcase
    end
    assign o_rdata = rdata;

    assign o_panel_half_height     = {panel_control_one[`LPC_C1_HALF9], panel_half_height};
    assign o_vertical_image_offset = {panel_control_one[`LPC_C1_ROW9], vertical_image_offset};
    assign o_panel_width_nibbles   = {panel_control_one[`LPC_C1_WIDTH9], panel_width_nibbles};
    assign o_column_pan_offset     = {panel_control_one[`LPC_C1_COL9], column_pan_offset};
    assign o_start_addr_top        = start_addr_a_top_bits[1:0];
    assign o_cursor_addr_top       = cursor_loc_top_bits[1:0];
    assign o_force16               = panel_control_two[`LPC_C2_FORCE16];
    assign o_legacy_color          = i_lcd_mode & panel_control_three[`LPC_C3_LEGACY];
    assign o_mclk_ga               = i_mclk ^ panel_control_three[`LPC_C3_MCLKINV];

    // Open-collector pin: only ever pulls low, floats for a one.
    assign o_irq_pin_out  = 1'b0;
    assign o_irq_pin_oe_n = ~(panel_control_one[`LPC_C1_FRADDR] & ~i_frame_addr8);

    assign o_pixel_out           = {o_gray, o_gray};
    assign o_pixel_oe_n          = panel_control_three[`LPC_C3_TRISTATE];
    assign o_video_dot_clock_out = i_dot_clk;
    assign o_dot_clock_oe_n      = panel_control_three[`LPC_C3_TRISTATE];

    // The raw line clock, retrace and lower-half inputs come from the line clock generator and are synchronised here.
    always @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lc_s1 <= 1'b0;
            lc_s2 <= 1'b0;
            lc_d  <= 1'b0;
            rt_s1 <= 1'b0;
            rt_s2 <= 1'b0;
            lh_s1 <= 1'b0;
            lh_s2 <= 1'b0;
            lh_d  <= 1'b0;
        end
        else
        begin
            lc_s1 <= i_line_clk_raw;
            lc_s2 <= lc_s1;
            lc_d  <= lc_s2;
            rt_s1 <= i_retrace;
            rt_s2 <= rt_s1;
            lh_s1 <= i_lower_half_start;
            lh_s2 <= lh_s1;
            lh_d  <= lh_s2;
        end
    end
    assign line_edge  = lc_s2 & ~lc_d;
    assign lower_edge = lh_s2 & ~lh_d;

    // The extra pulse is issued on the first idle cycle after the lower half begins.
    always @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_line_clk <= 1'b0;
            extra_pend <= 1'b0;
        end
        else
        begin
            if (lower_edge & panel_control_one[`LPC_C1_EXTRA])
                extra_pend <= 1'b1;
            else if (extra_pend & ~line_edge & ~o_line_clk)
                extra_pend <= 1'b0;
            if (line_edge)
                o_line_clk <= ~rt_s2 | panel_control_one[`LPC_C1_RETRACE];
            else
                o_line_clk <= extra_pend & ~o_line_clk;
        end
    end

    // AC inversion toggles every period+1 line clocks; a zero period toggles each line.
    always @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ac_count    <= 8'h00;
            o_ac_invert <= 1'b0;
        end
        else if (o_line_clk)
        begin
            if (ac_count >= ac_inversion_period)
            begin
                ac_count    <= 8'h00;
                o_ac_invert <= ~o_ac_invert;
            end
            else
                ac_count <= ac_count + 8'h01;
        end
    end

    // Vertical placement: the row offset places the image unless centering is on or the mode is expanded.
    assign blank_lines = (i_panel_lines > i_image_lines) ? i_panel_lines - i_image_lines
                                                         : {LINE_W{1'b0}};
    assign first_image_line = top_blank;
    always @*
    begin
        if (panel_control_one[`LPC_C1_CENTER] & ~i_expanded)
            top_blank = {1'b0, blank_lines[LINE_W-1:1]};
        else if (i_expanded)
            top_blank = {LINE_W{1'b0}};
        else
            top_blank = {{(LINE_W-9){1'b0}}, o_vertical_image_offset};
    end

    // Lines past the image stay blank, so an uncentred short mode with a zero row offset leaves its blank at the bottom.
    always @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
            o_image_active <= 1'b0;
        else
            o_image_active <= (i_line_num >= first_image_line) &&
                              (i_line_num < first_image_line + i_image_lines);
    end

    // Gray waveform phase advances by the offset on each displayed line after the first.
    always @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_gray_phase   <= 4'h0;
            first_line     <= 1'b1;
            o_vert_stipple <= 1'b0;
        end
        else
        begin
            o_vert_stipple <= gray_line_offset[`LPC_GR_STIPPLE];
            if (i_frame_start)
            begin
                o_gray_phase <= 4'h0;
                first_line   <= 1'b1;
            end
            else if (line_edge & o_image_active)
            begin
                first_line <= 1'b0;
                if (!first_line)
                    o_gray_phase <= o_gray_phase + gray_line_offset[3:0];
            end
        end
    end

    // Internal 256x4 palette, loaded with sum-to-gray results.
    always @(posedge i_clock)
    begin
        if (i_palette_we)
            palette[i_palette_addr] <= i_palette_gray;
        pal_gray <= palette[i_pixel_index];
    end

    always @*
    begin
        if (panel_control_two[`LPC_C2_PALETTE] & ~o_legacy_color)
            pix_gray = pal_gray;
        else
            pix_gray = i_pixel_gray;
        if (i_text_mode & panel_control_two[`LPC_C2_ATTR])
            pix_gray = i_text_contrast_gray ? `LPC_GRAY_MAX : `LPC_GRAY_MIN;
        if (i_lcd_mode & i_text_mode & panel_control_two[`LPC_C2_REVERSE])
            pix_gray = ~pix_gray;
        if (i_border | ~i_pixel_valid)
            next_gray = border_gray_shade[3:0];
        else
            next_gray = pix_gray;
    end

    // Reduction of a nine-pixel group to eight.
    always @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_gray       <= 4'h0;
            o_reduced    <= 2'b00;
            o_drop_pixel <= 1'b0;
        end
        else
        begin
            o_gray <= next_gray;
            case ({panel_control_two[`LPC_C2_RED_HI], panel_control_two[`LPC_C2_RED_LO]})
                2'b10:
                begin
                    o_reduced    <= i_row9_pixels[1:0];
                    o_drop_pixel <= 1'b1;
                end
                2'b11:
                begin
                    o_reduced    <= {i_row9_pixels[1] | i_row9_pixels[0], 1'b0};
                    o_drop_pixel <= 1'b1;
                end
                default:
                begin
                    o_reduced    <= i_row9_pixels[1:0];
                    o_drop_pixel <= 1'b0;
                end
            endcase
        end
    end

endmodule // lpc_panel_control
`default_nettype wire

// [testbench/lpc_panel_props.sv]
// Port-level assertions for the panel control block.
`timescale 1ns/1ps
`default_nettype none
module lpc_panel_props (
    // Clock, reset and register port
    input wire logic       i_clock,
    input wire logic       i_nrst,
    input wire logic [7:0] i_index,
    input wire logic [7:0] i_wdata,
    input wire logic       i_write,
    input wire logic [7:0] o_rdata,
    // Timing and pass-through sources
    input wire logic       i_lcd_mode,
    input wire logic       i_mclk,
    input wire logic       i_frame_addr8,
    input wire logic       i_line_clk_raw,
    input wire logic       i_retrace,
    // Outputs
    input wire logic       o_line_clk,
    input wire logic       o_irq_pin_out,
    input wire logic       o_irq_pin_oe_n,
    input wire logic       o_pixel_oe_n,
    input wire logic       o_dot_clock_oe_n,
    input wire logic       o_mclk_ga,
    input wire logic       o_force16,
    input wire logic       o_legacy_color,
    input wire logic [1:0] o_start_addr_top,
    input wire logic [1:0] o_cursor_addr_top,
    input wire logic [8:0] o_panel_half_height,
    input wire logic [8:0] o_vertical_image_offset,
    input wire logic [8:0] o_panel_width_nibbles,
    input wire logic [8:0] o_column_pan_offset
);
    default clocking dc @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);

    a_write_back: assert property ((i_write && i_index == 8'hd5) |=>
        (i_index != 8'hd5 || o_rdata == $past(i_wdata))) else $error("write lost");
    a_pins_float: assert property (o_pixel_oe_n == o_dot_clock_oe_n &&
        (i_index != 8'hdb || o_pixel_oe_n == o_rdata[5])) else $error("float mismatch");
    a_mclk_invert: assert property ((i_index == 8'hdb) |->
        o_mclk_ga == (i_mclk ^ o_rdata[6])) else $error("memory clock wrong");
    a_legacy_map: assert property ((i_index == 8'hdb) |->
        o_legacy_color == (i_lcd_mode && o_rdata[7])) else $error("legacy map wrong");
    a_wide_access: assert property ((i_index == 8'hd5) |->
        o_force16 == o_rdata[4]) else $error("force wide wrong");
    a_start_top: assert property ((i_index == 8'h26) |->
        {o_rdata[7:2], o_start_addr_top} == {6'h00, o_rdata[1:0]}) else $error("start top");
    a_cursor_top: assert property ((i_index == 8'h27) |->
        {o_rdata[7:2], o_cursor_addr_top} == {6'h00, o_rdata[1:0]}) else $error("cursor top");
    a_ninth_bits: assert property ((i_index == 8'hd4) |-> o_rdata[7:4] ==
        {o_panel_half_height[8], o_vertical_image_offset[8], o_panel_width_nibbles[8],
         o_column_pan_offset[8]}) else $error("ninth bits wrong");
    a_irq_pull: assert property (!o_irq_pin_out && (i_index != 8'hd4 ||
        o_irq_pin_oe_n == !(o_rdata[1] && !i_frame_addr8))) else $error("irq pin wrong");
    a_line_follow: assert property ($rose(i_line_clk_raw) && !i_retrace &&
        !$past(i_retrace) |-> ##[2:4] o_line_clk) else $error("line clock missing");
    a_line_pulse: assert property (o_line_clk |=> !o_line_clk)
        else $error("line clock too long");
endmodule // lpc_panel_props
`default_nettype wire

// [testbench/lpc_panel_side.sv]
// Panel-side timing source: raw line clock, retrace and lower-half marker.
`timescale 1ns/1ps
`default_nettype none
module lpc_panel_side (
    // Clock
    input  wire logic i_clock,
    // Panel timing
    output var logic  o_line_raw,
    output var logic  o_retrace,
    output var logic  o_lower_half
);
    initial
    begin
        o_line_raw   = 1'b0;
        o_retrace    = 1'b0;
        o_lower_half = 1'b0;
    end

    // Levels last two cycles so the two-flop synchroniser cannot miss one.
    task automatic lines(input int n, input logic retr, input logic lower);
        @(negedge i_clock);
        o_retrace = retr;
        repeat (4) @(negedge i_clock);
        for (int i = 0; i < n; i++)
        begin
            o_line_raw = 1'b1;
            repeat (2) @(negedge i_clock);
            o_line_raw = 1'b0;
            repeat (2) @(negedge i_clock);
            o_lower_half = lower && i == 1;
            repeat (2) @(negedge i_clock);
            o_lower_half = 1'b0;
            repeat (4) @(negedge i_clock);
        end
        o_retrace = 1'b0;
    endtask
endmodule // lpc_panel_side
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the panel control block.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_regs.vh"
module tb;
    logic       i_clock, i_nrst, i_write, i_lcd_mode, i_text_mode, i_expanded;
    logic       i_frame_start, i_frame_addr8, i_mclk, i_pixel_valid, i_border;
    logic       i_text_contrast_gray, i_palette_we, i_dot_clk;
    logic [7:0] i_index, i_wdata, i_pixel_index, i_palette_addr;
    logic [3:0] i_pixel_gray, i_palette_gray;
    logic [8:0] i_row9_pixels;
    logic [9:0] i_image_lines, i_panel_lines, i_line_num;
    wire        line_raw, retrace, lower_half, o_line_clk, o_ac_invert, o_drop_pixel;
    wire        o_irq_pin_out, o_irq_pin_oe_n, o_pixel_oe_n, o_dot_clock_oe_n;
    wire        o_mclk_ga, o_legacy_color, o_vert_stipple;
    wire [7:0]  o_rdata;
    wire [3:0]  o_gray;
    wire [8:0]  o_panel_half_height, o_column_pan_offset;
    logic [7:0] model [0:255];
    logic [7:0] idx_list [0:13] = '{8'h26, 8'h27, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4,
                                    8'hd5, 8'hd6, 8'hd7, 8'hd9, 8'hda, 8'hdb, 8'he0};
    logic [95:0] rnd;
    int         n_fail, total_checks, pulses, k;

    lpc_panel_side i_panel (.i_clock(i_clock), .o_line_raw(line_raw), .o_retrace(retrace),
        .o_lower_half(lower_half));
    lpc_panel_control #(.LINE_W(10)) i_dut (.i_clock(i_clock), .i_nrst(i_nrst),
        .i_index(i_index), .i_wdata(i_wdata), .i_write(i_write), .o_rdata(o_rdata),
        .i_lcd_mode(i_lcd_mode), .i_text_mode(i_text_mode), .i_expanded(i_expanded),
        .i_line_clk_raw(line_raw), .i_retrace(retrace), .i_frame_start(i_frame_start),
        .i_image_lines(i_image_lines), .i_panel_lines(i_panel_lines), .i_line_num(i_line_num),
        .i_lower_half_start(lower_half), .i_frame_addr8(i_frame_addr8), .i_mclk(i_mclk),
        .i_pixel_index(i_pixel_index), .i_pixel_gray(i_pixel_gray),
        .i_pixel_valid(i_pixel_valid), .i_border(i_border),
        .i_text_contrast_gray(i_text_contrast_gray), .i_row9_pixels(i_row9_pixels),
        .i_palette_we(i_palette_we), .i_palette_addr(i_palette_addr),
        .i_palette_gray(i_palette_gray), .i_dot_clk(i_dot_clk), .o_line_clk(o_line_clk),
        .o_ac_invert(o_ac_invert), .o_gray(o_gray), .o_reduced(), .o_drop_pixel(o_drop_pixel),
        .o_image_active(), .o_gray_phase(), .o_vert_stipple(o_vert_stipple),
        .o_irq_pin_out(o_irq_pin_out),
        .o_irq_pin_oe_n(o_irq_pin_oe_n), .o_pixel_out(), .o_pixel_oe_n(o_pixel_oe_n),
        .o_video_dot_clock_out(), .o_dot_clock_oe_n(o_dot_clock_oe_n), .o_mclk_ga(o_mclk_ga),
        .o_force16(), .o_legacy_color(o_legacy_color), .o_start_addr_top(),
        .o_cursor_addr_top(), .o_panel_half_height(o_panel_half_height),
        .o_vertical_image_offset(), .o_panel_width_nibbles(),
        .o_column_pan_offset(o_column_pan_offset));

    function automatic logic [7:0] mask_of(input logic [7:0] idx);
        case (idx)
            8'h26, 8'h27: mask_of = `LPC_MASK_TOP;
            8'hd6: mask_of = `LPC_MASK_GRAY;
            8'hda: mask_of = `LPC_MASK_BORDER;
            8'hdb: mask_of = `LPC_MASK_CTL3;
            8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd9: mask_of = 8'hff;
            default: mask_of = 8'h00;
        endcase
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(negedge i_clock);
        {i_index, i_wdata, i_write} = {idx, d, 1'b1};
        @(negedge i_clock);
        i_write = 1'b0;
        model[idx] = d & mask_of(idx);
    endtask

    task automatic rd(input logic [7:0] idx);
        @(negedge i_clock);
        i_index = idx;
        #1;
        check(o_rdata, model[idx]);
    endtask

    // Writes are only safe once the internal two-flop reset copy has let go.
    task automatic do_reset();
        @(negedge i_clock);
        i_nrst = 1'b0;
        repeat (6) @(negedge i_clock);
        i_nrst = 1'b1;
        repeat (3) @(negedge i_clock);
        for (int i = 0; i < 256; i++)
            model[i] = 8'h00;
        model[8'hd6] = `LPC_RST_GRAY_VAL;
        pulses = 0;
    endtask

    initial
    begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end

    initial
    begin
        repeat (100000) @(posedge i_clock);
        n_fail++;
        tally_and_finish();
    end

    always @(posedge i_clock)
        if (o_line_clk === 1'b1)
            pulses++;

    always @(negedge i_clock)
    begin
        rnd = {$urandom, $urandom, $urandom};
        {i_mclk, i_dot_clk, i_frame_start, i_text_contrast_gray, i_palette_we} <= rnd[4:0];
        {i_pixel_index, i_pixel_gray, i_row9_pixels, i_palette_addr, i_palette_gray} <= rnd[37:5];
        {i_image_lines, i_panel_lines, i_line_num} <= rnd[67:38];
    end

    initial
    begin
        {i_nrst, i_write, i_index, i_wdata, i_frame_addr8, i_border, i_expanded} = '0;
        {i_lcd_mode, i_text_mode, i_pixel_valid} = 3'b111;
        k = $urandom(48062);
        do_reset();
        foreach (idx_list[j])
            rd(idx_list[j]);
        $display("test reset values done");
        foreach (idx_list[j])
        begin
            wr(idx_list[j], 8'($urandom));
            rd(idx_list[j]);
        end
        check(o_panel_half_height, {model[8'hd4][7], model[8'hd3]});
        check(o_vert_stipple, model[8'hd6][7]);
        wr(8'hd0, 8'h50);
        wr(8'hd3, 8'hef);
        wr(8'hd2, 8'h1a);
        check(o_column_pan_offset, {model[8'hd4][4], 8'h50});
        $display("test register access done");
        for (int v = 0; v < 8; v++)
        begin
            i_lcd_mode = v[1];
            wr(`LPC_IDX_CTL3, {v[2:0], 5'h00});
            #1;
            check({o_pixel_oe_n, o_dot_clock_oe_n}, {2{v[0]}});
            check(o_mclk_ga, i_mclk ^ v[1]);
            check(o_legacy_color, v[1] & v[2]);
        end
        wr(`LPC_IDX_CTL1, 8'h02);
        for (int a = 0; a < 2; a++)
        begin
            i_frame_addr8 = a[0];
            #1;
            check({o_irq_pin_out, o_irq_pin_oe_n}, {1'b0, a[0]});
        end
        i_frame_addr8 = 1'b0;
        wr(`LPC_IDX_CTL1, 8'h00);
        check(o_irq_pin_oe_n, 1'b1);
        $display("test pin control done");
        for (int c = 0; c < 4; c++)
        begin
            wr(`LPC_IDX_CTL1, c == 2 ? 8'h01 : (c == 3 ? 8'h04 : 8'h00));
            pulses = 0;
            i_panel.lines(4, c == 1 || c == 2, c == 3);
            repeat (8) @(negedge i_clock);
            check(16'(pulses), 16'(c == 1 ? 0 : (c == 3 ? 5 : 4)));
        end
        $display("test line clocks done");
        for (int p = 0; p < 3; p++)
        begin
            do_reset();
            wr(`LPC_IDX_ACINV, p[7:0]);
            i_panel.lines(7, 1'b0, 1'b0);
            repeat (8) @(negedge i_clock);
            check(o_ac_invert, 16'((7 / (p + 1)) % 2));
        end
        $display("test ac inversion done");
        wr(`LPC_IDX_CTL2, 8'h40);
        {i_text_mode, i_lcd_mode, i_border} = 3'b111;
        for (int s = 0; s < 16; s++)
        begin
            wr(`LPC_IDX_BORDER, s[7:0]);
            repeat (3) @(negedge i_clock);
            check(o_gray, s[3:0]);
        end
        i_border = 1'b0;
        wr(`LPC_IDX_CTL2, 8'h60);
        @(negedge i_clock);
        check(o_gray, i_text_contrast_gray ? 4'h0 : 4'hf);
        for (int m = 0; m < 4; m++)
        begin
            wr(`LPC_IDX_CTL2, m[7:0]);
            repeat (3) @(negedge i_clock);
            check(o_drop_pixel, m >= 2);
        end
        $display("test pixel path done");
        tally_and_finish();
    end
endmodule // tb

bind lpc_panel_control lpc_panel_props i_props (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_index(i_index), .i_wdata(i_wdata), .i_write(i_write), .o_rdata(o_rdata),
    .i_lcd_mode(i_lcd_mode), .i_mclk(i_mclk), .i_frame_addr8(i_frame_addr8),
    .i_line_clk_raw(i_line_clk_raw), .i_retrace(i_retrace), .o_line_clk(o_line_clk),
    .o_irq_pin_out(o_irq_pin_out), .o_irq_pin_oe_n(o_irq_pin_oe_n),
    .o_pixel_oe_n(o_pixel_oe_n), .o_dot_clock_oe_n(o_dot_clock_oe_n), .o_mclk_ga(o_mclk_ga),
    .o_force16(o_force16), .o_legacy_color(o_legacy_color),
    .o_start_addr_top(o_start_addr_top), .o_cursor_addr_top(o_cursor_addr_top),
    .o_panel_half_height(o_panel_half_height),
    .o_vertical_image_offset(o_vertical_image_offset),
    .o_panel_width_nibbles(o_panel_width_nibbles), .o_column_pan_offset(o_column_pan_offset));
`default_nettype wire
